// file: hw/seq_pkg.sv
// constants, state types and timing counts for the dual-rail sleep sequencer
// assumes a 20 MHz free-running timebase and a supply-monitor reset
// Contract
// - decode both-high as active, level5-high level3-low as S3, both-low as S4/S5
// - block illegal changes, never go straight from S4/S5 into S3
// - level5 low with level3 high keeps the previous state
// - standard variant turns the standby P gate on only in S3
// - always-on variant turns the standby P gate on in S3 and S4/S5
// - wait 60us after an active-to-S3 request before performing it
// - active-to-S4/S5 happens at once with no added delay
// - deglitch both sleep inputs against short spurious pulses
// - self-initialise at power-up and hold all sequencing in reset on low standby
// - never enter active until the 12V monitor reports the rail up
// - after standby reset release wait one soft-start interval, then soft-start
// - ramp the 3.3V dual rail under a stepped digital reference
// - always-on variant sinks soft current from standby P gate during soft-start
// - at end of soft-start pull the standby P gate pin fully low
// - count three soft-start intervals after 12V is up before entering active
// - on entering active release the open-drain N gate pin
// - together with that release drive the standby P gate pin high
// - together with that release put the internal regulator in standby
// - hold the open-drain N gate pin low while the N switches must be off
// - sense the 12V rail power-on-reset level at the N gate pin
// - regulate 3.3V internally in sleep, external N switch supplies it in active
// - watch the 3.3V output for undervoltage in S3 and S4/S5
// - undervoltage acts only in sleep after soft-start; disable, retry one interval later
// - fourth undervoltage after three retries latches the regulator off until reset
`default_nettype none
package seq_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // soft-start interval, typical figure
  localparam int SS_INTERVAL_NS = 8200000;
  localparam int SS_CYCLES = SS_INTERVAL_NS / CLK_PERIOD_NS;
  // active to S3 delay, a least time so it rounds up
  localparam int S3_DELAY_NS = 60000;
  localparam int S3_DELAY_CYCLES = (S3_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACTIVE_WAIT_INTERVALS = 3;
  localparam int UV_RETRIES = 3;
  localparam int DEGLITCH_CYCLES = 16;
  localparam int REF_W = 8;
  localparam int TMR_W = 18;
  localparam logic [REF_W-1:0] REF_RESET = 8'h00;
  localparam logic [REF_W-1:0] REF_FULL = 8'hff;
  localparam logic [1:0] POWER_CODE_S0 = 2'h0;
  localparam logic [1:0] POWER_CODE_S3 = 2'h1;
  localparam logic [1:0] POWER_CODE_S45 = 2'h2;

  typedef enum logic [1:0] {PWR_S0, PWR_S3, PWR_S45} power_state_t;

  typedef enum logic [2:0] {
    ST_POR_WAIT, ST_SOFTSTART, ST_SLEEP, ST_WAIT12,
    ST_ACTIVE, ST_S3_DELAY, ST_UV_OFF, ST_LATCHED
  } seq_state_t;
endpackage
`default_nettype wire

// file: hw/sleep_deglitch.sv
// stability filter for one sleep-state input
// assumes the raw level is already synchronous to clk
`default_nettype none
module sleep_deglitch #(
  parameter int STABLE_CYCLES = seq_pkg::DEGLITCH_CYCLES,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level in and filtered level out
  input wire logic raw_in,
  output logic clean_out
);
  typedef struct packed {
    logic clean;
    logic [CNT_W-1:0] cnt;
  } filt_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(STABLE_CYCLES - 1);

  filt_t s_reg;
  filt_t s_next;

  // ------------------------------------------------------------
  // filter
  // ------------------------------------------------------------
  // stable count
  always_comb begin
    s_next = s_reg;
    if (raw_in == s_reg.clean) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt == LAST) begin
      s_next.clean = raw_in;
      s_next.cnt = '0;
    end else begin
      s_next.cnt = s_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign clean_out = s_reg.clean;
endmodule
`default_nettype wire

// file: hw/acpi_dual_rail_sequencer.sv
// sequencing logic of the two-rail sleep power controller
// assumes rstn is the standby-supply monitor and all inputs are synchronous to clk
`default_nettype none
module acpi_dual_rail_sequencer #(
  parameter bit ALWAYS_ON = 1'b0,
  parameter int SS_CYCLES = seq_pkg::SS_CYCLES,
  parameter int DEGLITCH_CYCLES = seq_pkg::DEGLITCH_CYCLES
) (
  // clock and supply-monitor reset
  input wire logic clk,
  input wire logic rstn,
  // sleep-state inputs from the chipset
  input wire logic sleep_level3_in_n,
  input wire logic sleep_level5_in_n,
  // open-drain N gate pin: level sensed, drive value, enable
  input wire logic nfet_gate_release_in,
  output logic nfet_gate_release_out,
  output logic nfet_gate_release_oe_n,
  // standby P gate pin drives
  output logic standby_pfet_gate_high,
  output logic standby_pfet_gate_low,
  output logic standby_pfet_gate_sink,
  // internal regulator control and its undervoltage comparator
  input wire logic aux_rail_uv,
  output logic aux_rail_ldo_enable,
  output logic aux_rail_ldo_standby,
  output logic [seq_pkg::REF_W-1:0] aux_rail_ss_ref,
  output logic aux_rail_latched_off,
  // state indication
  output logic [1:0] power_state
);
  localparam int TW = seq_pkg::TMR_W;
  localparam int RW = seq_pkg::REF_W;
  localparam int REF_STEPS = 256;
  localparam int STEP_CYCLES = (SS_CYCLES >= REF_STEPS) ? (SS_CYCLES / REF_STEPS) : 1;
  localparam logic [TW-1:0] SS_LAST = TW'(SS_CYCLES - 1);
  localparam logic [TW-1:0] STEP_LAST = TW'(STEP_CYCLES - 1);
  localparam logic [TW-1:0] DELAY_LAST = TW'(seq_pkg::S3_DELAY_CYCLES - 1);
  localparam logic [1:0] IVL_LAST = 2'(seq_pkg::ACTIVE_WAIT_INTERVALS - 1);
  localparam logic [1:0] RETRY_MAX = 2'(seq_pkg::UV_RETRIES);

  typedef struct packed {
    seq_pkg::seq_state_t st;
    seq_pkg::power_state_t kind;
    seq_pkg::power_state_t req;
    logic [TW-1:0] tmr;
    logic [1:0] ivl;
    logic [RW-1:0] ss_ref;
    logic [1:0] retries;
    logic nfet_oe_n;
    logic pfet_hi;
    logic pfet_lo;
    logic pfet_sink;
    logic ldo_en;
    logic ldo_stby;
    logic latched;
    logic [1:0] pwr;
  } seq_t;

  seq_t s_reg;
  seq_t s_next;
  logic l3_clean;
  logic l5_clean;

  // ------------------------------------------------------------
  // input filtering
  // ------------------------------------------------------------
  // deglitch level3
  sleep_deglitch #(
    .STABLE_CYCLES(DEGLITCH_CYCLES),
    .CNT_W(8)
  ) u_l3_filter (
    .clk(clk),
    .rstn(rstn),
    .raw_in(sleep_level3_in_n),
    .clean_out(l3_clean)
  );

  sleep_deglitch #(
    .STABLE_CYCLES(DEGLITCH_CYCLES),
    .CNT_W(8)
  ) u_l5_filter (
    .clk(clk),
    .rstn(rstn),
    .raw_in(sleep_level5_in_n),
    .clean_out(l5_clean)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic seq_pkg::power_state_t decode_req(
    input logic l5,
    input logic l3,
    input seq_pkg::power_state_t prev
  );
    seq_pkg::power_state_t r;
    r = prev;
    if (l5 && l3) begin
      r = seq_pkg::PWR_S0;
    end else if (l5 && !l3) begin
      r = seq_pkg::PWR_S3;
    end else if (!l5 && !l3) begin
      r = seq_pkg::PWR_S45;
    end else begin
      r = prev;
    end
    return r;
  endfunction

  function automatic logic pfet_wanted(input seq_pkg::power_state_t k);
    return (k == seq_pkg::PWR_S3) || (ALWAYS_ON && (k == seq_pkg::PWR_S45));
  endfunction

  function automatic seq_pkg::power_state_t legal_kind(
    input seq_pkg::power_state_t cur,
    input seq_pkg::power_state_t want
  );
    seq_pkg::power_state_t k;
    k = want;
    if ((cur == seq_pkg::PWR_S45) && (want == seq_pkg::PWR_S3)) begin
      k = cur;
    end
    return k;
  endfunction

  function automatic logic [1:0] power_code(input seq_pkg::power_state_t k);
    logic [1:0] c;
    c = seq_pkg::POWER_CODE_S45;
    if (k == seq_pkg::PWR_S0) begin
      c = seq_pkg::POWER_CODE_S0;
    end else if (k == seq_pkg::PWR_S3) begin
      c = seq_pkg::POWER_CODE_S3;
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.req = decode_req(l5_clean, l3_clean, s_reg.req);
    s_next.tmr = s_reg.tmr + TW'(1);
    unique case (s_reg.st)
      seq_pkg::ST_POR_WAIT: begin
        if (s_next.req != seq_pkg::PWR_S0) begin
          s_next.kind = s_next.req;
        end
        if (s_reg.tmr == SS_LAST) begin
          s_next.st = seq_pkg::ST_SOFTSTART;
          s_next.tmr = '0;
          s_next.ss_ref = seq_pkg::REF_RESET;
        end
      end
      seq_pkg::ST_SOFTSTART: begin
        if (s_reg.tmr == STEP_LAST) begin
          s_next.tmr = '0;
          if (s_reg.ss_ref == seq_pkg::REF_FULL) begin
            s_next.st = seq_pkg::ST_SLEEP;
          end else begin
            s_next.ss_ref = s_reg.ss_ref + RW'(1);
          end
        end
      end
      seq_pkg::ST_SLEEP, seq_pkg::ST_WAIT12: begin
        if (aux_rail_uv) begin
          s_next.tmr = '0;
          if (s_reg.retries == RETRY_MAX) begin
            s_next.st = seq_pkg::ST_LATCHED;
          end else begin
            s_next.retries = s_reg.retries + 2'h1;
            s_next.st = seq_pkg::ST_UV_OFF;
          end
        end else if (s_next.req != seq_pkg::PWR_S0) begin
          s_next.kind = legal_kind(s_reg.kind, s_next.req);
          s_next.st = seq_pkg::ST_SLEEP;
        end else if (s_reg.st == seq_pkg::ST_SLEEP) begin
          s_next.st = seq_pkg::ST_WAIT12;
          s_next.tmr = '0;
          s_next.ivl = '0;
        end else if (!nfet_gate_release_in) begin
          s_next.tmr = '0;
          s_next.ivl = '0;
        end else if (s_reg.tmr == SS_LAST) begin
          s_next.tmr = '0;
          if (s_reg.ivl == IVL_LAST) begin
            s_next.st = seq_pkg::ST_ACTIVE;
          end else begin
            s_next.ivl = s_reg.ivl + 2'h1;
          end
        end
      end
      seq_pkg::ST_ACTIVE: begin
        if (s_next.req == seq_pkg::PWR_S45) begin
          s_next.kind = seq_pkg::PWR_S45;
          s_next.st = seq_pkg::ST_SLEEP;
        end else if (s_next.req == seq_pkg::PWR_S3) begin
          s_next.st = seq_pkg::ST_S3_DELAY;
          s_next.tmr = '0;
        end
      end
      seq_pkg::ST_S3_DELAY: begin
        if (s_next.req == seq_pkg::PWR_S45) begin
          s_next.kind = seq_pkg::PWR_S45;
          s_next.st = seq_pkg::ST_SLEEP;
        end else if (s_next.req == seq_pkg::PWR_S0) begin
          s_next.st = seq_pkg::ST_ACTIVE;
        end else if (s_reg.tmr == DELAY_LAST) begin
          s_next.kind = seq_pkg::PWR_S3;
          s_next.st = seq_pkg::ST_SLEEP;
        end
      end
      seq_pkg::ST_UV_OFF: begin
        if (s_next.req != seq_pkg::PWR_S0) begin
          s_next.kind = legal_kind(s_reg.kind, s_next.req);
        end
        if (s_reg.tmr == SS_LAST) begin
          s_next.st = seq_pkg::ST_SOFTSTART;
          s_next.tmr = '0;
          s_next.ss_ref = seq_pkg::REF_RESET;
        end
      end
      seq_pkg::ST_LATCHED: begin
        // only a supply reset leaves this state
        s_next.tmr = s_reg.tmr;
      end
      default: begin
        s_next.st = seq_pkg::ST_POR_WAIT;
        s_next.tmr = '0;
      end
    endcase

    // outputs follow the next state so they leave flip-flops in step with it
    s_next.nfet_oe_n = 1'b0;
    s_next.pfet_hi = 1'b1;
    s_next.pfet_lo = 1'b0;
    s_next.pfet_sink = 1'b0;
    s_next.ldo_en = 1'b0;
    s_next.ldo_stby = 1'b0;
    s_next.latched = 1'b0;
    s_next.pwr = power_code(s_next.kind);
    unique case (s_next.st)
      seq_pkg::ST_SOFTSTART: begin
        s_next.ldo_en = 1'b1;
        if (ALWAYS_ON) begin
          s_next.pfet_hi = 1'b0;
          s_next.pfet_sink = 1'b1;
        end
      end
      seq_pkg::ST_SLEEP, seq_pkg::ST_WAIT12: begin
        s_next.ldo_en = 1'b1;
        s_next.pfet_lo = pfet_wanted(s_next.kind);
        s_next.pfet_hi = !pfet_wanted(s_next.kind);
      end
      seq_pkg::ST_ACTIVE, seq_pkg::ST_S3_DELAY: begin
        s_next.nfet_oe_n = 1'b1;
        s_next.pfet_hi = 1'b1;
        s_next.ldo_en = 1'b1;
        s_next.ldo_stby = 1'b1;
        s_next.pwr = seq_pkg::POWER_CODE_S0;
      end
      seq_pkg::ST_UV_OFF, seq_pkg::ST_LATCHED: begin
        s_next.pfet_lo = pfet_wanted(s_next.kind);
        s_next.pfet_hi = !pfet_wanted(s_next.kind);
        s_next.latched = (s_next.st == seq_pkg::ST_LATCHED);
      end
      default: begin
        s_next.pfet_hi = 1'b1;
      end
    endcase
    if (s_next.st != seq_pkg::ST_ACTIVE && s_next.st != seq_pkg::ST_S3_DELAY) begin
      s_next.nfet_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg.st <= seq_pkg::ST_POR_WAIT;
      s_reg.kind <= seq_pkg::PWR_S45;
      s_reg.req <= seq_pkg::PWR_S45;
      s_reg.tmr <= '0;
      s_reg.ivl <= '0;
      s_reg.ss_ref <= seq_pkg::REF_RESET;
      s_reg.retries <= '0;
      s_reg.nfet_oe_n <= 1'b0;
      s_reg.pfet_hi <= 1'b1;
      s_reg.pfet_lo <= 1'b0;
      s_reg.pfet_sink <= 1'b0;
      s_reg.ldo_en <= 1'b0;
      s_reg.ldo_stby <= 1'b0;
      s_reg.latched <= 1'b0;
      s_reg.pwr <= seq_pkg::POWER_CODE_S45;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  // the open-drain pin only ever pulls low; the high level is the board pull-up
  assign nfet_gate_release_out = 1'b0;
  assign nfet_gate_release_oe_n = s_reg.nfet_oe_n;
  assign standby_pfet_gate_high = s_reg.pfet_hi;
  assign standby_pfet_gate_low = s_reg.pfet_lo;
  assign standby_pfet_gate_sink = s_reg.pfet_sink;
  assign aux_rail_ldo_enable = s_reg.ldo_en;
  assign aux_rail_ldo_standby = s_reg.ldo_stby;
  assign aux_rail_ss_ref = s_reg.ss_ref;
  assign aux_rail_latched_off = s_reg.latched;
  assign power_state = s_reg.pwr;
endmodule
`default_nettype wire

// file: dv/seq_chk.sv
// port assertions for the dual-rail sleep sequencer
// assumes it is bound to acpi_dual_rail_sequencer
`default_nettype none
module seq_chk #(
  parameter bit ALWAYS_ON = 1'b0,
  parameter int SS_CYCLES = seq_pkg::SS_CYCLES,
  parameter int DEGLITCH_CYCLES = seq_pkg::DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // design ports
  input wire logic sleep_level3_in_n,
  input wire logic sleep_level5_in_n,
  input wire logic nfet_gate_release_in,
  input wire logic nfet_gate_release_out,
  input wire logic nfet_gate_release_oe_n,
  input wire logic standby_pfet_gate_high,
  input wire logic standby_pfet_gate_low,
  input wire logic standby_pfet_gate_sink,
  input wire logic aux_rail_uv,
  input wire logic aux_rail_ldo_enable,
  input wire logic aux_rail_ldo_standby,
  input wire logic [seq_pkg::REF_W-1:0] aux_rail_ss_ref,
  input wire logic aux_rail_latched_off,
  input wire logic [1:0] power_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------
  // helper counts of stable input levels and of cycles since reset
  // ----------
  int por_cnt, s3_cnt, s45_cnt, rail_cnt;
  logic ldo_seen, s45_act;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt <= 0;
      s3_cnt <= 0;
      s45_cnt <= 0;
      rail_cnt <= 0;
      ldo_seen <= 1'b0;
      s45_act <= 1'b0;
    end else begin
      por_cnt <= por_cnt + 1;
      s3_cnt <= (sleep_level5_in_n && !sleep_level3_in_n) ? s3_cnt + 1 : 0;
      s45_cnt <= (!sleep_level5_in_n && !sleep_level3_in_n) ? s45_cnt + 1 : 0;
      rail_cnt <= nfet_gate_release_in ? rail_cnt + 1 : 0;
      ldo_seen <= ldo_seen | aux_rail_ldo_enable;
      if (s45_cnt == 0) begin
        s45_act <= nfet_gate_release_oe_n;
      end
    end
  end
  // ----------
  // assertions
  // ----------
  rst_vals_a: assert property ($rose(rstn) |-> power_state == 2'h2 && !aux_rail_ldo_enable)
    else $error("bad outputs after reset");
  ss_wait_a: assert property (aux_rail_ldo_enable && !ldo_seen |-> por_cnt >= SS_CYCLES - 1)
    else $error("soft-start began early");
  ref_step_a: assert property (aux_rail_ldo_enable && $past(aux_rail_ldo_enable)
    |-> {1'b0, aux_rail_ss_ref} - {1'b0, $past(aux_rail_ss_ref)} <= 9'h001) else $error("reference jumped");
  s3_delay_a: assert property ($past(power_state) == 2'h0 && power_state == 2'h1
    |-> s3_cnt >= seq_pkg::S3_DELAY_CYCLES) else $error("sleep level 3 entered early");
  s45_fast_a: assert property (s45_cnt == DEGLITCH_CYCLES + 3 && s45_act
    |-> power_state == 2'h2 && !nfet_gate_release_oe_n) else $error("deep sleep entry late");
  wake_rail_a: assert property ($rose(nfet_gate_release_oe_n) |-> rail_cnt >= 3 * SS_CYCLES - 2)
    else $error("active entered without rail wait");
  wake_same_a: assert property ($rose(nfet_gate_release_oe_n) |-> standby_pfet_gate_high
    && aux_rail_ldo_standby && power_state == 2'h0) else $error("active entry actions split");
  oe_low_a: assert property (power_state != 2'h0 |-> !nfet_gate_release_oe_n && !nfet_gate_release_out)
    else $error("n gate released in sleep");
  pfet_one_a: assert property ($onehot({standby_pfet_gate_high, standby_pfet_gate_low,
    standby_pfet_gate_sink})) else $error("p gate drives overlap");
  pfet_low_a: assert property (standby_pfet_gate_low |-> power_state != 2'h0
    && (ALWAYS_ON || power_state == 2'h1)) else $error("p gate on in wrong state");
  soft_sink_a: assert property (standby_pfet_gate_sink |-> ALWAYS_ON && aux_rail_ldo_enable)
    else $error("soft sink outside soft-start");
  latch_hold_a: assert property (aux_rail_latched_off |=> aux_rail_latched_off && !aux_rail_ldo_enable)
    else $error("latch released");
  cover property ($rose(nfet_gate_release_oe_n));
  cover property ($past(power_state) == 2'h0 && power_state == 2'h1);
  cover property ($rose(aux_rail_latched_off));
endmodule
bind acpi_dual_rail_sequencer seq_chk #(.ALWAYS_ON(ALWAYS_ON), .SS_CYCLES(SS_CYCLES),
  .DEGLITCH_CYCLES(DEGLITCH_CYCLES)) seq_chk_i (.clk, .rstn, .sleep_level3_in_n, .sleep_level5_in_n,
  .nfet_gate_release_in, .nfet_gate_release_out, .nfet_gate_release_oe_n, .standby_pfet_gate_high,
  .standby_pfet_gate_low, .standby_pfet_gate_sink, .aux_rail_uv, .aux_rail_ldo_enable,
  .aux_rail_ldo_standby, .aux_rail_ss_ref, .aux_rail_latched_off, .power_state);
`default_nettype wire

// file: dv/power_partner.sv
// far side: chipset sleep lines, 12V rail sense, 3.3V output droop
// assumes the bench changes commands just after a clock edge
`default_nettype none
module power_partner (
  // bench commands: {level5, level3}, 12V up, output short
  input wire logic [1:0] req,
  input wire logic rail_on,
  input wire logic short_on,
  // lines into the sequencer
  output logic host_sleep_level5_n,
  output logic host_sleep_level3_n,
  output logic rail_sense,
  output logic uv
);
  timeunit 1ns;
  timeprecision 1ns;
  // chipset gives 5-low/3-high only when commanded
  assign host_sleep_level5_n = req[1];
  assign host_sleep_level3_n = req[0];
  // the pin only senses high once the 12V pull-up rail is up
  assign rail_sense = rail_on;
  assign uv = short_on;
endmodule
`default_nettype wire

// file: dv/acpi_dual_rail_sequencer_tb_top.sv
// self-checking bench for the dual-rail sleep sequencer
// assumes shortened soft-start and deglitch counts
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module acpi_dual_rail_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SS = 512;
  localparam int DG = 4;
  logic clk, rstn, rail_on, short_on, l3_n, l5_n, rail_sense, uv;
  logic oe_n, p_high, p_low, p_sink, ldo_en, ldo_sb, latched;
  logic a_high, a_low, a_sink;
  logic [1:0] req, power_state;
  logic [seq_pkg::REF_W-1:0] ss_ref;
  int err_total = 0;
  int tests_run = 0;
  int n;
  power_partner power_partner_i (.req, .rail_on, .short_on, .host_sleep_level5_n(l5_n),
    .host_sleep_level3_n(l3_n), .rail_sense, .uv);
  acpi_dual_rail_sequencer #(.SS_CYCLES(SS), .DEGLITCH_CYCLES(DG)) acpi_dual_rail_sequencer_i (
    .clk, .rstn, .sleep_level3_in_n(l3_n), .sleep_level5_in_n(l5_n), .nfet_gate_release_in(rail_sense),
    .nfet_gate_release_out(), .nfet_gate_release_oe_n(oe_n), .standby_pfet_gate_high(p_high),
    .standby_pfet_gate_low(p_low), .standby_pfet_gate_sink(p_sink), .aux_rail_uv(uv),
    .aux_rail_ldo_enable(ldo_en), .aux_rail_ldo_standby(ldo_sb), .aux_rail_ss_ref(ss_ref),
    .aux_rail_latched_off(latched), .power_state);
  // always-on variant on the same inputs; only its gate drives differ from the standard one
  if (1) begin : aon_g
    acpi_dual_rail_sequencer #(.ALWAYS_ON(1'b1), .SS_CYCLES(SS), .DEGLITCH_CYCLES(DG)) acpi_dual_rail_sequencer_i (
      .clk, .rstn, .sleep_level3_in_n(l3_n), .sleep_level5_in_n(l5_n), .nfet_gate_release_in(rail_sense),
      .nfet_gate_release_out(), .nfet_gate_release_oe_n(), .standby_pfet_gate_high(a_high),
      .standby_pfet_gate_low(a_low), .standby_pfet_gate_sink(a_sink), .aux_rail_uv(uv),
      .aux_rail_ldo_enable(), .aux_rail_ldo_standby(), .aux_rail_ss_ref(), .aux_rail_latched_off(),
      .power_state());
  end
  // ----------
  // helpers
  // ----------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic drive(input logic [1:0] r);
    @(posedge clk);
    req <= r;
    #1;
  endtask
  // bounded waits; n keeps the cycles spent
  task automatic wait_ps(input logic [1:0] want, input int lim);
    n = 0;
    while (power_state !== want && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_powerup;
    `CHK("ps_rst", 2'h2, power_state)
    `CHK("pfet_rst", 1'b1, p_high)
    @(posedge clk);
    rstn <= 1'b1;
    cyc(SS - 4);
    `CHK("ldo_wait", 1'b0, ldo_en)
    wait_hi(ldo_en, 20);
    `CHK("ldo_on", 1'b1, ldo_en)
    cyc(100);
    `CHK("ref_mid", 1'b1, ss_ref > 8'h00 && ss_ref < 8'hff)
    `CHK("aon_sink", 1'b1, a_sink)
    `CHK("aon_hi_ss", 1'b0, a_high)
    `CHK("std_sink", 1'b0, p_sink)
    cyc(450);
    `CHK("ref_full", 8'hff, ss_ref)
    `CHK("pfet_s45", 1'b1, p_high)
    `CHK("ps_s45", 2'h2, power_state)
    `CHK("aon_s45", 1'b1, a_low)
    `CHK("aon_sink_end", 1'b0, a_sink)
    $display("t_powerup done");
  endtask
  task automatic t_wake;
    drive(2'b11);
    cyc(3 * SS + 50);
    `CHK("no_rail", 1'b0, oe_n)
    @(posedge clk);
    rail_on <= 1'b1;
    wait_hi(oe_n, 4 * SS);
    `CHK("wait3", 1'b1, n >= 3 * SS && n <= 3 * SS + 8)
    `CHK("p_off", 1'b1, p_high)
    `CHK("ldo_sb", 1'b1, ldo_sb)
    `CHK("ps_s0", 2'h0, power_state)
    `CHK("aon_p_off", 1'b1, a_high)
    // an undervoltage pulse in the active state must be ignored
    @(posedge clk);
    short_on <= 1'b1;
    @(posedge clk);
    short_on <= 1'b0;
    cyc(3);
    `CHK("uv_active", 1'b1, oe_n)
    `CHK("uv_act_ldo", 1'b1, ldo_en)
    $display("t_wake done");
  endtask
  task automatic t_glitch;
    drive(2'b01);
    cyc(20);
    drive(2'b00);
    cyc(DG - 3);
    drive(2'b11);
    cyc(20);
    `CHK("ps_kept", 2'h0, power_state)
    `CHK("oe_kept", 1'b1, oe_n)
    $display("t_glitch done");
  endtask
  task automatic t_s3;
    drive(2'b10);
    wait_ps(2'h1, 1500);
    `CHK("s3_delay", 1'b1, n >= 1200 && n < 1500)
    cyc(2);
    `CHK("p_on_s3", 1'b1, p_low)
    `CHK("aon_s3", 1'b1, a_low)
    drive(2'b00);
    wait_ps(2'h2, DG + 4);
    cyc(2);
    `CHK("p_off_s45", 1'b1, p_high)
    drive(2'b10);
    cyc(50);
    `CHK("no_s45_s3", 2'h2, power_state)
    drive(2'b11);
    wait_hi(oe_n, 4 * SS);
    drive(2'b00);
    wait_ps(2'h2, 20);
    `CHK("s45_fast", 1'b1, n <= DG + 3)
    `CHK("oe_low", 1'b0, oe_n)
    $display("t_s3 done");
  endtask
  task automatic t_uv;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      short_on <= 1'b1;
      @(posedge clk);
      short_on <= 1'b0;
      cyc(3);
      `CHK("uv_off", 1'b0, ldo_en)
      if (i < 3) begin
        cyc(SS - 10);
        `CHK("retry_wait", 1'b0, ldo_en)
        cyc(20 + 2 * 257 + 10);
      end
    end
    `CHK("latched", 1'b1, latched)
    drive(2'b11);
    cyc(3 * SS + 50);
    `CHK("latch_hold", 1'b0, ldo_en)
    @(posedge clk);
    rstn <= 1'b0;
    cyc(2);
    `CHK("latch_clr", 1'b0, latched)
    `CHK("oe_rst", 1'b0, oe_n)
    @(posedge clk);
    rstn <= 1'b1;
    cyc(SS + 20);
    `CHK("restart", 1'b1, ldo_en)
    $display("t_uv done");
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    req = 2'b00;
    rail_on = 1'b0;
    short_on = 1'b0;
    cyc(4);
    t_powerup();
    t_wake();
    t_glitch();
    t_s3();
    t_uv();
    give_verdict();
  end
  // a hang is cut off well past the expected 12.3k cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
